// *** core/mhc_pkg.sv ***
// Constants for the maintenance hours counter: timing, widths, register map, fields.
// Assumes a 20 MHz core clock; the counter, top, checker and bench import this package.
package mhc_pkg;

   // Timing
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned CLK_PER_US     = CLK_HZ / 1_000_000;
   localparam int unsigned MINUTE_S       = 60;
   localparam int unsigned MINUTE_CYCLES  = MINUTE_S * CLK_HZ;
   localparam int unsigned SCAN_PERIOD_US = 10_000;
   localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_US * CLK_PER_US;

   // Widths
   localparam int RT_HW  = 17;
   localparam int IV_HW  = 14;
   localparam int MIN_W  = 6;
   localparam int TOT_W  = 23;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 3;
   localparam int IRQ_W  = 3;
   localparam int CTRL_W = 3;

   // Limits
   localparam logic [RT_HW-1:0] RT_MAX_HOURS = 17'h1869f;
   localparam logic [IV_HW-1:0] IV_MAX_HOURS = 14'h270f;
   localparam logic [MIN_W-1:0] MIN_LAST     = 6'h3b;
   localparam logic [TOT_W-1:0] MIN_PER_HOUR = 23'h00003c;

   // Register word addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_INTERVAL = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET   = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_RUNTIME  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_TTG      = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h5;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h6;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h7;

   // Field positions
   localparam int CTRL_RUN_BIT    = 0;
   localparam int CTRL_POLICY_BIT = 1;
   localparam int CTRL_SRC_BIT    = 2;
   localparam int HM_HOURS_LSB    = 0;
   localparam int HM_MIN_LSB      = 24;
   localparam int ST_ALARM_BIT    = 0;
   localparam int ST_MONITOR_BIT  = 1;
   localparam int ST_SAT_BIT      = 2;
   localparam int ST_PFIRED_BIT   = 3;
   localparam int IRQ_ALARM_BIT   = 0;
   localparam int IRQ_SAT_BIT     = 1;
   localparam int IRQ_RELOAD_BIT  = 2;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST     = 3'h0;
   localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;

   // Output-clear policy
   typedef enum logic {
      MHC_CLR_RESET    = 1'b0,
      MHC_CLR_RESET_EN = 1'b1
   } mhc_clr_policy_t;

endpackage

// *** core/mhc_hm_if.sv ***
// Hours/minutes counter link between the control logic and one counter instance.
// Assumes one controller and one counter per instance.
`timescale 1ns/1ps
interface mhc_hm_if #(parameter int HW = 17);
   logic                      load;
   logic [HW-1:0]             load_hours;
   logic [mhc_pkg::MIN_W-1:0] load_minutes;
   logic                      step;
   logic [HW-1:0]             hours;
   logic [mhc_pkg::MIN_W-1:0] minutes;
   logic                      at_limit;

   modport ctl (output load, load_hours, load_minutes, step, input hours, minutes, at_limit);
   modport cnt (input load, load_hours, load_minutes, step, output hours, minutes, at_limit);
endinterface

// *** core/mhc_hm_counter.sv ***
// One hours/minutes counter that counts up with saturation or down to zero.
// Assumes the controller drives load during reset so the state is always defined.
`timescale 1ns/1ps
module mhc_hm_counter #(
   parameter int              HW        = 17,
   parameter logic [HW-1:0]   MAX_HOURS = '1,
   parameter bit              DOWN      = 1'b0
) (
   // Clock
   input  wire logic clk,
   // Control link
   mhc_hm_if.cnt     hm
);
   import mhc_pkg::*;

   logic [HW-1:0]    hours_reg;
   logic [MIN_W-1:0] minutes_reg;

   // Down stops at 0:00, up stops once the hour limit is hit
   assign hm.at_limit = DOWN ? (hours_reg == '0 && minutes_reg == '0)
                             : (hours_reg == MAX_HOURS);
   assign hm.hours    = hours_reg;
   assign hm.minutes  = minutes_reg;

   // Load wins over a step; a step at the limit is dropped rather than wrapping
   always_ff @(posedge clk) begin
      if (hm.load) begin
         hours_reg   <= hm.load_hours;
         minutes_reg <= hm.load_minutes;
      end else if (hm.step && !hm.at_limit) begin
         if (DOWN) begin
            if (minutes_reg == '0) begin
               hours_reg   <= hours_reg - 1'b1;
               minutes_reg <= MIN_LAST;
            end else begin
               minutes_reg <= minutes_reg - 1'b1;
            end
         end else begin
            if (minutes_reg == MIN_LAST) begin
               hours_reg   <= hours_reg + 1'b1;
               minutes_reg <= '0;
            end else begin
               minutes_reg <= minutes_reg + 1'b1;
            end
         end
      end
   end

endmodule // mhc_hm_counter

// *** core/mhc_counter_top.sv ***
// Maintenance hours counter: run-time totaliser, time-to-go and alarm, with register port.
// Assumes synchronous inputs at 20 MHz and an external non-volatile image on restore/retain.
// Function
// - Partial reset edge clears alarm, reloads time-to-go; run time kept.
// - Full reset edge clears alarm, zeroes run time, reloads time-to-go.
// - Monitor high advances run time and lowers time-to-go; low holds both.
// - Alarm is set when time-to-go reaches zero.
// - Policy bit: clear on reset inputs, or additionally while monitor low.
// - Service period is hours 0..9999 plus minutes 0..59.
// - Run time saturates at 99999 hours and stops there.
// - Run time keeps counting regardless of partial reset level.
// - Period, time-to-go and run time are always retained, never volatile.
// - Period comes from a configured constant or a live external value.
// - Offset with no partial reset yet: time-to-go = period - run mod period.
// - Run time not writable in run mode; a period change in run mode reloads time-to-go.
`timescale 1ns/1ps
module mhc_counter_top
   import mhc_pkg::*;
#(
   parameter int unsigned SCAN_TICKS   = SCAN_CYCLES,
   parameter int unsigned MINUTE_TICKS = MINUTE_CYCLES
) (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Register port
   input  wire logic [mhc_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [mhc_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [mhc_pkg::DATA_W-1:0]   reg_rdata,
   // Circuit program signals
   input  wire logic                         monitor,
   input  wire logic                         partial_reset,
   input  wire logic                         full_reset,
   output logic                              alarm,
   output logic                              irq,
   // Live service period from another block
   input  wire logic [15:0]                  ext_period_hours,
   input  wire logic [7:0]                   ext_period_minutes,
   // Retention image, loaded while in reset
   input  wire logic [mhc_pkg::IV_HW-1:0]    restore_period_hours,
   input  wire logic [mhc_pkg::MIN_W-1:0]    restore_period_minutes,
   input  wire logic [mhc_pkg::RT_HW-1:0]    restore_run_hours,
   input  wire logic [mhc_pkg::MIN_W-1:0]    restore_run_minutes,
   input  wire logic [mhc_pkg::IV_HW-1:0]    restore_ttg_hours,
   input  wire logic [mhc_pkg::MIN_W-1:0]    restore_ttg_minutes,
   input  wire logic                         restore_partial_fired,
   // Retention image, live copy for the backing store
   output logic      [mhc_pkg::IV_HW-1:0]    retain_period_hours,
   output logic      [mhc_pkg::MIN_W-1:0]    retain_period_minutes,
   output logic      [mhc_pkg::RT_HW-1:0]    retain_run_hours,
   output logic      [mhc_pkg::MIN_W-1:0]    retain_run_minutes,
   output logic      [mhc_pkg::IV_HW-1:0]    retain_ttg_hours,
   output logic      [mhc_pkg::MIN_W-1:0]    retain_ttg_minutes,
   output logic                              retain_partial_fired
);

   mhc_hm_if #(.HW(RT_HW)) rt_if ();
   mhc_hm_if #(.HW(IV_HW)) ttg_if ();

   logic [CTRL_W-1:0] ctrl_reg;
   logic [IV_HW-1:0]  cfg_hours_reg;
   logic [MIN_W-1:0]  cfg_minutes_reg;
   logic [IV_HW-1:0]  prev_hours_reg;
   logic [MIN_W-1:0]  prev_minutes_reg;
   logic              part_d_reg;
   logic              full_d_reg;
   logic              partial_fired_reg;
   logic [31:0]       scan_cnt_reg;
   logic              monitor_smp_reg;
   logic [31:0]       minute_cnt_reg;
   logic              alarm_reg;
   logic              alarm_next;
   logic              sat_d_reg;
   logic [IRQ_W-1:0]  irq_stat_reg;
   logic [IRQ_W-1:0]  irq_stat_next;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic [IRQ_W-1:0]  irq_events;
   logic [DATA_W-1:0] rdata_reg;

   logic              run_mode;
   mhc_clr_policy_t   policy;
   logic              part_edge;
   logic              full_edge;
   logic              scan_tick;
   logic              minute_tick;
   logic [IV_HW-1:0]  per_hours;
   logic [MIN_W-1:0]  per_minutes;
   logic              per_changed;
   logic              off_wr;
   logic [RT_HW-1:0]  off_hours;
   logic [MIN_W-1:0]  off_minutes;
   logic [TOT_W-1:0]  run_total;
   logic [TOT_W-1:0]  per_total;
   logic [TOT_W-1:0]  ttg_total;
   logic [IV_HW-1:0]  der_hours;
   logic [MIN_W-1:0]  der_minutes;

   assign run_mode  = ctrl_reg[CTRL_RUN_BIT];
   assign policy    = mhc_clr_policy_t'(ctrl_reg[CTRL_POLICY_BIT]);
   assign part_edge = partial_reset & ~part_d_reg;
   assign full_edge = full_reset & ~full_d_reg;

   // Edge memory for both reset inputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         part_d_reg <= 1'b0;
         full_d_reg <= 1'b0;
      end else begin
         part_d_reg <= partial_reset;
         full_d_reg <= full_reset;
      end
   end

   // Program scan: the monitor is looked at once per scan, like the relay cycle
   assign scan_tick = (scan_cnt_reg == 32'(SCAN_TICKS - 1));
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scan_cnt_reg    <= 32'h0;
         monitor_smp_reg <= 1'b0;
      end else begin
         scan_cnt_reg <= scan_tick ? 32'h0 : scan_cnt_reg + 32'h1;
         if (scan_tick) begin
            monitor_smp_reg <= monitor;
         end
      end
   end

   // Minute base counts on-time only; a partial minute survives a monitor low phase
   assign minute_tick = monitor_smp_reg && (minute_cnt_reg == 32'(MINUTE_TICKS - 1));
   always_ff @(posedge clk) begin
      if (!rst_n || full_edge) begin
         minute_cnt_reg <= 32'h0;
      end else if (minute_tick) begin
         minute_cnt_reg <= 32'h0;
      end else if (monitor_smp_reg) begin
         minute_cnt_reg <= minute_cnt_reg + 32'h1;
      end
   end

   // Service period source; out-of-range live values clamp to the nearest legal value
   always_comb begin
      per_hours   = cfg_hours_reg;
      per_minutes = cfg_minutes_reg;
      if (ctrl_reg[CTRL_SRC_BIT]) begin
         per_hours   = (ext_period_hours > 16'(IV_MAX_HOURS)) ? IV_MAX_HOURS
                                                               : ext_period_hours[IV_HW-1:0];
         per_minutes = (ext_period_minutes > 8'(MIN_LAST)) ? MIN_LAST
                                                            : ext_period_minutes[MIN_W-1:0];
      end
   end
   assign per_changed = run_mode && ((per_hours != prev_hours_reg) ||
                                     (per_minutes != prev_minutes_reg));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_hours_reg   <= restore_period_hours;
         prev_minutes_reg <= restore_period_minutes;
      end else begin
         prev_hours_reg   <= per_hours;
         prev_minutes_reg <= per_minutes;
      end
   end

   // Offset write is accepted outside run mode only
   assign off_wr      = reg_wr && (reg_addr == ADDR_OFFSET) && !run_mode;
   assign off_hours   = (reg_wdata[HM_HOURS_LSB +: RT_HW] > RT_MAX_HOURS) ? RT_MAX_HOURS
                                                             : reg_wdata[HM_HOURS_LSB +: RT_HW];
   assign off_minutes = (reg_wdata[HM_MIN_LSB +: MIN_W] > MIN_LAST) ? MIN_LAST
                                                             : reg_wdata[HM_MIN_LSB +: MIN_W];

   // Time-to-go derived from an offset; the divider is only used on that rare write
   always_comb begin
      run_total = TOT_W'(off_hours) * MIN_PER_HOUR + TOT_W'(off_minutes);
      per_total = TOT_W'(per_hours) * MIN_PER_HOUR + TOT_W'(per_minutes);
      ttg_total = '0;
      if (per_total != '0) begin
         ttg_total = per_total - (run_total % per_total);
      end
      der_hours   = IV_HW'(ttg_total / MIN_PER_HOUR);
      der_minutes = MIN_W'(ttg_total % MIN_PER_HOUR);
   end

   // Run-time counter control
   always_comb begin
      rt_if.load         = 1'b1;
      rt_if.load_hours   = restore_run_hours;
      rt_if.load_minutes = restore_run_minutes;
      if (rst_n) begin
         if (full_edge) begin
            rt_if.load_hours   = '0;
            rt_if.load_minutes = '0;
         end else if (off_wr) begin
            rt_if.load_hours   = off_hours;
            rt_if.load_minutes = off_minutes;
         end else begin
            rt_if.load = 1'b0;
         end
      end
   end
   assign rt_if.step = minute_tick;

   // Time-to-go control, resets first, then offset, then a live period change
   always_comb begin
      ttg_if.load         = 1'b1;
      ttg_if.load_hours   = restore_ttg_hours;
      ttg_if.load_minutes = restore_ttg_minutes;
      if (rst_n) begin
         if (full_edge || part_edge) begin
            ttg_if.load_hours   = per_hours;
            ttg_if.load_minutes = per_minutes;
         end else if (off_wr && !partial_fired_reg) begin
            ttg_if.load_hours   = der_hours;
            ttg_if.load_minutes = der_minutes;
         end else if (per_changed) begin
            ttg_if.load_hours   = per_hours;
            ttg_if.load_minutes = per_minutes;
         end else begin
            ttg_if.load = 1'b0;
         end
      end
   end
   assign ttg_if.step = minute_tick;

   mhc_hm_counter #(
      .HW        (RT_HW),
      .MAX_HOURS (RT_MAX_HOURS),
      .DOWN      (1'b0)
   ) u_run_time (
      .clk (clk),
      .hm  (rt_if.cnt)
   );

   mhc_hm_counter #(
      .HW        (IV_HW),
      .MAX_HOURS (IV_MAX_HOURS),
      .DOWN      (1'b1)
   ) u_time_to_go (
      .clk (clk),
      .hm  (ttg_if.cnt)
   );

   // Whether a partial reset has ever fired; retained with the counters
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         partial_fired_reg <= restore_partial_fired;
      end else if (part_edge) begin
         partial_fired_reg <= 1'b1;
      end
   end

   // Alarm: set at zero time-to-go, cleared per the selected policy
   always_comb begin
      alarm_next = ttg_if.at_limit;
      if (partial_reset || full_reset) begin
         alarm_next = 1'b0;
      end else if (policy == MHC_CLR_RESET_EN && !monitor_smp_reg) begin
         alarm_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alarm_reg <= 1'b0;
         sat_d_reg <= 1'b0;
      end else begin
         alarm_reg <= alarm_next;
         sat_d_reg <= rt_if.at_limit;
      end
   end

   // Control and configured period; period write in run mode reloads via per_changed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg        <= CTRL_RST;
         cfg_hours_reg   <= restore_period_hours;
         cfg_minutes_reg <= restore_period_minutes;
         irq_mask_reg    <= IRQ_MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
         end
         if (reg_addr == ADDR_INTERVAL) begin
            cfg_hours_reg   <= (reg_wdata[HM_HOURS_LSB +: IV_HW] > IV_MAX_HOURS) ? IV_MAX_HOURS
                                                             : reg_wdata[HM_HOURS_LSB +: IV_HW];
            cfg_minutes_reg <= off_minutes;
         end
         if (reg_addr == ADDR_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[IRQ_W-1:0];
         end
      end
   end

   // Sticky events; a new event in the clearing cycle survives the write-one-to-clear
   always_comb begin
      irq_events                 = '0;
      irq_events[IRQ_ALARM_BIT]  = alarm_next & ~alarm_reg;
      irq_events[IRQ_SAT_BIT]    = rt_if.at_limit & ~sat_d_reg;
      irq_events[IRQ_RELOAD_BIT] = part_edge | full_edge;
      irq_stat_next              = irq_stat_reg;
      if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~reg_wdata[IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_events;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   // Read data stand for exactly the cycle after the strobe; without a read they give zero
   always_ff @(posedge clk) begin
      if (!rst_n || !reg_rd) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= '0;
         unique case (reg_addr)
            ADDR_CTRL: begin
               rdata_reg[CTRL_W-1:0] <= ctrl_reg;
            end
            ADDR_INTERVAL: begin
               rdata_reg[HM_HOURS_LSB +: IV_HW] <= per_hours;
               rdata_reg[HM_MIN_LSB +: MIN_W]   <= per_minutes;
            end
            ADDR_OFFSET, ADDR_RUNTIME: begin
               rdata_reg[HM_HOURS_LSB +: RT_HW] <= rt_if.hours;
               rdata_reg[HM_MIN_LSB +: MIN_W]   <= rt_if.minutes;
            end
            ADDR_TTG: begin
               rdata_reg[HM_HOURS_LSB +: IV_HW] <= ttg_if.hours;
               rdata_reg[HM_MIN_LSB +: MIN_W]   <= ttg_if.minutes;
            end
            ADDR_STATUS: begin
               rdata_reg[ST_ALARM_BIT]   <= alarm_reg;
               rdata_reg[ST_MONITOR_BIT] <= monitor_smp_reg;
               rdata_reg[ST_SAT_BIT]     <= rt_if.at_limit;
               rdata_reg[ST_PFIRED_BIT]  <= partial_fired_reg;
            end
            ADDR_IRQ_STAT: begin
               rdata_reg[IRQ_W-1:0] <= irq_stat_reg;
            end
            ADDR_IRQ_MASK: begin
               rdata_reg[IRQ_W-1:0] <= irq_mask_reg;
            end
         endcase
      end
   end

   // Outputs
   assign reg_rdata             = rdata_reg;
   assign alarm                 = alarm_reg;
   assign irq                   = |(irq_stat_reg & irq_mask_reg);
   assign retain_period_hours   = cfg_hours_reg;
   assign retain_period_minutes = cfg_minutes_reg;
   assign retain_run_hours      = rt_if.hours;
   assign retain_run_minutes    = rt_if.minutes;
   assign retain_ttg_hours      = ttg_if.hours;
   assign retain_ttg_minutes    = ttg_if.minutes;
   assign retain_partial_fired  = partial_fired_reg;

endmodule // mhc_counter_top

// *** verification/mhc_counter_asserts.sv ***
// Port checker for the maintenance hours counter top.
// Assumes one clock with a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module mhc_counter_asserts
   import mhc_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Circuit side
   input wire logic        monitor,
   input wire logic        partial_reset,
   input wire logic        full_reset,
   input wire logic        alarm,
   input wire logic [15:0] ext_period_hours,
   input wire logic [7:0]  ext_period_minutes,
   // Counter image
   input wire logic [16:0] retain_run_hours,
   input wire logic [5:0]  retain_run_minutes,
   input wire logic [13:0] retain_ttg_hours,
   input wire logic [5:0]  retain_ttg_minutes,
   // Retained period and partial-reset history
   input wire logic [13:0] retain_period_hours,
   input wire logic [5:0]  retain_period_minutes,
   input wire logic        retain_partial_fired
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Time-to-go at zero, both reset inputs quiet
   wire ttg0  = retain_ttg_hours == '0 && retain_ttg_minutes == '0;
   wire rst_q = !partial_reset && !full_reset;

   AST_PARTIAL_CLR: assert property ($rose(partial_reset) |=> !alarm)
      else $error("alarm kept after partial reset edge");
   AST_FULL_ZERO: assert property ($rose(full_reset) |=>
      !alarm && retain_run_hours == '0 && retain_run_minutes == '0)
      else $error("run time or alarm not cleared by full reset");
   // Eight low cycles guarantee at least one low scan sample
   AST_IDLE_HOLD: assert property ((!monitor && !full_reset && !reg_wr)[*8]
      |=> $stable(retain_run_minutes)) else $error("run time moved while idle");
   AST_ALARM_SET: assert property ((ttg0 && monitor && rst_q)[*6] |-> alarm)
      else $error("alarm low with time-to-go at zero");
   AST_RST_CLR: assert property ((partial_reset || full_reset) |=> !alarm)
      else $error("alarm high while a reset input is high");
   // A period write one cycle back still reloads time-to-go, so it is left out
   AST_TTG_FLOOR: assert property (ttg0 && rst_q && !reg_wr && !$past(reg_wr)
      && $stable(ext_period_hours) && $stable(ext_period_minutes) |=> ttg0)
      else $error("time-to-go left zero");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data without a read");
   AST_SAT_HOLD: assert property (retain_run_hours == RT_MAX_HOURS && !full_reset
      && !reg_wr |=> retain_run_hours == RT_MAX_HOURS) else $error("run time past limit");
   AST_PFIRED_SET: assert property ($rose(partial_reset) |=> retain_partial_fired)
      else $error("partial reset history not kept");
   // The period only moves on a register write
   AST_PERIOD_KEEP: assert property (!reg_wr |=> $stable(retain_period_hours)
      && $stable(retain_period_minutes)) else $error("service period moved without a write");

   // Main scenarios reached
   cover property ($rose(alarm));
   cover property ($rose(partial_reset));
   cover property (retain_run_hours == RT_MAX_HOURS && monitor);
endmodule // mhc_counter_asserts

bind mhc_counter_top mhc_counter_asserts u_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_rdata,
   .monitor, .partial_reset, .full_reset, .alarm, .ext_period_hours, .ext_period_minutes,
   .retain_run_hours, .retain_run_minutes, .retain_ttg_hours, .retain_ttg_minutes,
   .retain_period_hours, .retain_period_minutes, .retain_partial_fired);

// *** verification/mhc_far_side.sv ***
// Far-side stand-in: monitor program signal and a live period source.
// Assumes the bench commands the monitor level; the period source is fixed.
`timescale 1ns/1ps
module mhc_far_side (
   // Clock and command
   input wire logic    clk,
   input wire logic    run_cmd,
   // Program signals
   output logic        monitor,
   output logic [15:0] ext_period_hours,
   output logic [7:0]  ext_period_minutes
);
   // Monitor follows the command one edge later, like a scan output; one driver only
   always @(posedge clk) begin
      monitor <= run_cmd;
   end
   // Live value beyond the legal range, so the device has to clamp it
   assign ext_period_hours   = 16'h2710;
   assign ext_period_minutes = 8'h50;
endmodule // mhc_far_side

// *** verification/tb_top.sv ***
// Self-checking bench for the maintenance hours counter.
// Assumes short counts SCAN_TICKS 4, MINUTE_TICKS 8 and a 50 ns clock.
`timescale 1ns/1ps
module tb_top;
   import mhc_pkg::*;
   typedef struct {logic [2:0] a; logic [31:0] m; logic [31:0] e; logic [1:0] i;} mhc_note_t;
   mhc_note_t   q[$];
   logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_seen = 1'h0;
   logic        run_cmd = 1'h0, partial_reset = 1'h0, full_reset = 1'h0;
   logic        alarm, irq, monitor;
   logic [2:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic [15:0] ext_period_hours;
   logic [7:0]  ext_period_minutes, rs = 8'h46;
   logic [5:0]  pm = 6'h2;
   logic [16:0] rh = RT_MAX_HOURS;
   int          n_fail = 0, n_compared = 0, cyc = 0;

   function automatic logic [31:0] hm(logic [16:0] h, logic [5:0] m);
      return {2'h0, m, 7'h0, h};
   endfunction
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wt(int n);
      repeat (n) @(posedge clk);
   endtask
   // Strobes drop before the next call, so no edge sees two assignments
   task automatic wr(logic [2:0] a, logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      wt(1);
      reg_wr    <= 1'h0;
      wt(1);
   endtask
   task automatic rd(logic [2:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] i = 2'h2);
      q.push_back('{a, m, e, i});
      reg_addr <= a;
      reg_rd   <= 1'h1;
      wt(1);
      reg_rd   <= 1'h0;
      wt(1);
   endtask
   task automatic kick(logic f);
      full_reset    <= f;
      partial_reset <= !f;
      wt(2);
      full_reset    <= 1'h0;
      partial_reset <= 1'h0;
      wt(2);
   endtask
   task automatic till_alarm();
      repeat (300) if (alarm !== 1'h1) wt(1);
   endtask
   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      forever #25 clk = !clk;
   end
   // Read data stands one cycle after the strobe; irq checked beside it only on reads whose i[1] is clear
   always @(posedge clk) begin
      if (rd_seen) begin
         n_compared++;
         if ((reg_rdata & q[0].m) !== q[0].e || (!q[0].i[1] && irq !== q[0].i[0])) begin
            n_fail++;
            $display("Error reg %0h expected %h seen %h irq %b", q[0].a, q[0].e,
                     reg_rdata & q[0].m, irq);
         end
         void'(q.pop_front());
      end
      rd_seen <= reg_rd;
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         close_out();
      end
   end

   mhc_far_side u_far (.clk, .run_cmd, .monitor, .ext_period_hours, .ext_period_minutes);
   mhc_counter_top #(.SCAN_TICKS(4), .MINUTE_TICKS(8)) dut (.clk, .rst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .monitor, .partial_reset, .full_reset,
      .alarm, .irq, .ext_period_hours, .ext_period_minutes,
      .restore_period_hours(14'h0), .restore_period_minutes(pm), .restore_run_hours(rh),
      .restore_run_minutes(6'h0), .restore_ttg_hours({6'h0, rs}),
      .restore_ttg_minutes(rs[5:0]), .restore_partial_fired(1'h0),
      .retain_period_hours(), .retain_period_minutes(), .retain_run_hours(),
      .retain_run_minutes(), .retain_ttg_hours(), .retain_ttg_minutes(),
      .retain_partial_fired());

   initial begin
      rs <= lfsr(rs);
      wt(3);
      rst_n <= 1'h1;
      wt(1);
      rd(ADDR_INTERVAL, '1, hm(0, 2));
      rd(ADDR_RUNTIME, '1, hm(rh, 0));
      rd(ADDR_TTG, '1, hm({9'h0, rs}, rs[5:0]));
      // Run time sits at its limit while the monitor runs
      run_cmd <= 1'h1;
      wt(60);
      run_cmd <= 1'h0;
      wt(12);
      rd(ADDR_RUNTIME, '1, hm(rh, 0));
      rd(ADDR_STATUS, 32'h4, 32'h4);
      rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
      kick(1'h1);
      rd(ADDR_RUNTIME, '1, '0);
      rd(ADDR_TTG, '1, hm(0, 2));
      wr(ADDR_OFFSET, hm(0, 5));
      rd(ADDR_RUNTIME, '1, hm(0, 5));
      rd(ADDR_TTG, '1, hm(0, 1));
      // Count down to zero, then keep running past it
      wr(ADDR_IRQ_MASK, 32'h1);
      run_cmd <= 1'h1;
      till_alarm();
      wt(40);
      run_cmd <= 1'h0;
      wt(12);
      rd(ADDR_TTG, '1, '0, 2'h1);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      wr(ADDR_IRQ_STAT, 32'h7);
      rd(ADDR_IRQ_STAT, 32'h1, '0, 2'h0);
      kick(1'h0);
      rd(ADDR_TTG, '1, hm(0, 2));
      rd(ADDR_STATUS, 32'h9, 32'h8);
      rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
      // Second clear policy drops the alarm when the monitor goes low
      wr(ADDR_CTRL, 32'h2);
      run_cmd <= 1'h1;
      till_alarm();
      run_cmd <= 1'h0;
      wt(12);
      rd(ADDR_STATUS, 32'h1, '0);
      kick(1'h1);
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_OFFSET, hm(0, 7));
      rd(ADDR_RUNTIME, '1, '0);
      wr(ADDR_INTERVAL, hm(3, 4));
      rd(ADDR_TTG, '1, hm(3, 4));
      wr(ADDR_CTRL, 32'h5);
      rd(ADDR_INTERVAL, '1, hm(IV_MAX_HOURS, MIN_LAST));
      wt(2);
      close_out();
   end
endmodule // tb_top
